// >>> brcd_pkg.sv
// constants shared by the board reset, clock and address decode logic
// Function
// (R1) after power-up the reset generator holds board reset low for a fixed interval
// (R2) a valid reset stays low longer than eight processor clock periods
// (R3) during reset the timer chip loads latches and counters with maximum count
// (R4) reset halts timer counting, clears timer flags, sets its internal reset bit
// (R5) after reset every parallel port chip register reads as zero
// (R6) an outside party may assert reset through the bus connector like power-on
// (R7) divide the 4 MHz crystal reference by four into processor phases and 1 MHz
// (R8) chip-select decode looks only at address bits ten to fifteen
// (R9) three selects: shared port and timer, rom socket one, rom socket two
// (R10) rom sockets at C000-CFFF or F000-FFFF per build; peripherals at E400-E7FF
// (R11) scratch ram 0000-007F stays inside the processor; no board select raised
// (R12) each timer counts the 1 MHz clock or external gate and trigger inputs
// (R13) selects rise only during a valid memory cycle
package brcd_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int SYS_PERIOD_NS = 25;
    localparam int PROC_PERIOD_NS = 1000;
    localparam int VALID_RESET_PERIODS = 8;
    // strictly longer than eight processor periods, so one cycle on top of the rounded-up count
    localparam int MIN_LOW_CYCLES =
        (VALID_RESET_PERIODS * PROC_PERIOD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS + 1;
    localparam int POR_CYCLES_DEFAULT = 4000;
    localparam int HOLD_CNT_W = 16;
    localparam int CRYSTAL_DIVIDE = 4;
    localparam logic [1:0] PHASE_TWO_START = 2'h2;

    // ----------------------------------------------------------------
    // address map, in units of the upper address bits, except SCRATCH_END which is a full 16-bit address
    // ----------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int DEC_LSB = 10;
    localparam int DEC_W = 6;
    localparam logic [5:0] PERIPH_BLOCK = 6'h39;
    localparam logic [4:0] ROM_LOW_ONE = 5'h18;
    localparam logic [4:0] ROM_LOW_TWO = 5'h19;
    localparam logic [4:0] ROM_HIGH_ONE = 5'h1E;
    localparam logic [4:0] ROM_HIGH_TWO = 5'h1F;
    localparam logic [15:0] SCRATCH_END = 16'h007F;

    // ----------------------------------------------------------------
    // reset generator states
    // ----------------------------------------------------------------
    typedef enum logic [1:0]
    {
        ST_POWER_ON = 2'b00,
        ST_STRETCH = 2'b01,
        ST_RUN = 2'b10
    } brcd_rst_state_e;

endpackage

// >>> brcd_dec_if.sv
// carrier between the top module and the address decoder
`timescale 1ns/1ps
interface brcd_dec_if;
    logic [5:0] addrHigh;
    logic periphHit;
    logic romOneHit;
    logic romTwoHit;

    modport requester
    (
        output addrHigh,
        input periphHit,
        input romOneHit,
        input romTwoHit
    );

    modport decoder
    (
        input addrHigh,
        output periphHit,
        output romOneHit,
        output romTwoHit
    );
endinterface

// >>> brcd_addr_decoder.sv
// programmed decoder on the upper address bits
`timescale 1ns/1ps
module brcd_addr_decoder
#(
    parameter bit ROM_AT_TOP = 1'b0
)
(
    brcd_dec_if.decoder dec
);

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    function automatic logic romBlock(input logic [5:0] addrHigh, input logic [4:0] base);
        romBlock = (addrHigh[5:1] == base);
    endfunction

    always_comb
    begin
        // only bits ten to fifteen are seen, so every device aliases within its block
        dec.periphHit = (dec.addrHigh == brcd_pkg::PERIPH_BLOCK); // [R8] [R9] [R10]
        if (ROM_AT_TOP)
        begin
            dec.romOneHit = romBlock(dec.addrHigh, brcd_pkg::ROM_HIGH_ONE); // [R10]
            dec.romTwoHit = romBlock(dec.addrHigh, brcd_pkg::ROM_HIGH_TWO); // [R10]
        end
        else
        begin
            dec.romOneHit = romBlock(dec.addrHigh, brcd_pkg::ROM_LOW_ONE); // [R10]
            dec.romTwoHit = romBlock(dec.addrHigh, brcd_pkg::ROM_LOW_TWO); // [R10]
        end
    end

endmodule

// >>> brcd_top.sv
// board reset generator, processor clock divider, timer clock source and chip selects
`timescale 1ns/1ps
module brcd_top
#(
    parameter int POR_CYCLES = brcd_pkg::POR_CYCLES_DEFAULT,
    parameter bit ROM_AT_TOP = 1'b0
)
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire logic crystalRef,
    input wire logic extResetN,
    input wire logic [15:0] addrBus,
    input wire logic validMemoryCycle,
    input wire logic timerSourceExt,
    input wire logic timerExtGate,
    output logic boardResetN,
    output logic procPhaseOne,
    output logic procPhaseTwo,
    output logic phaseTwoClk,
    output logic periphSelect,
    output logic romSocketOneSelect,
    output logic romSocketTwoSelect,
    output logic timerPresetHold,
    output logic timerCountTick,
    output logic portClearHold
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    localparam int HOLD_MAX = (1 << brcd_pkg::HOLD_CNT_W) - 1;

    if (POR_CYCLES < brcd_pkg::MIN_LOW_CYCLES || POR_CYCLES > HOLD_MAX)
    begin : g_bad_por
        $error("POR_CYCLES must cover a valid reset and fit the hold counter");
    end

    // ----------------------------------------------------------------
    // reset generator
    // ----------------------------------------------------------------
    localparam logic [15:0] POR_LOAD = 16'(POR_CYCLES);
    localparam logic [15:0] MIN_LOAD = 16'(brcd_pkg::MIN_LOW_CYCLES);

    brcd_pkg::brcd_rst_state_e rstState;
    brcd_pkg::brcd_rst_state_e next_rstState;
    logic [15:0] holdCnt;
    logic [15:0] next_holdCnt;
    logic next_boardResetN;

    always_comb
    begin
        next_rstState = rstState;
        next_holdCnt = holdCnt;
        case (rstState)
            brcd_pkg::ST_POWER_ON:
            begin
                // one-shot after power-up, independent of the connector line
                if (holdCnt <= 16'h0001) // [R1]
                begin
                    next_rstState = brcd_pkg::ST_STRETCH;
                    next_holdCnt = MIN_LOAD;
                end
                else
                begin
                    next_holdCnt = holdCnt - 16'h0001;
                end
            end
            brcd_pkg::ST_STRETCH:
            begin
                if (!extResetN)
                begin
                    next_holdCnt = MIN_LOAD; // [R2]
                end
                else if (holdCnt <= 16'h0001)
                begin
                    next_rstState = brcd_pkg::ST_RUN;
                end
                else
                begin
                    next_holdCnt = holdCnt - 16'h0001;
                end
            end
            brcd_pkg::ST_RUN:
            begin
                // a short glitch on the connector is stretched to a valid reset
                if (!extResetN) // [R6]
                begin
                    next_rstState = brcd_pkg::ST_STRETCH;
                    next_holdCnt = MIN_LOAD; // [R2]
                end
            end
            default:
            begin
                next_rstState = brcd_pkg::ST_POWER_ON;
                next_holdCnt = POR_LOAD;
            end
        endcase
        next_boardResetN = (next_rstState == brcd_pkg::ST_RUN);
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rstState <= brcd_pkg::ST_POWER_ON;
            holdCnt <= POR_LOAD;
            boardResetN <= 1'b0;
        end
        else if (clkEn)
        begin
            rstState <= next_rstState;
            holdCnt <= next_holdCnt;
            boardResetN <= next_boardResetN;
        end
    end

    // ----------------------------------------------------------------
    // crystal divide-by-four into the two processor phases
    // ----------------------------------------------------------------
    localparam logic [1:0] PHASE_LAST = 2'(brcd_pkg::CRYSTAL_DIVIDE - 1);

    logic crystalPrev;
    logic [1:0] phaseCnt;
    logic [1:0] next_phaseCnt;
    logic next_phaseTwo;
    logic phaseTwoRise;

    always_comb
    begin
        next_phaseCnt = phaseCnt;
        // inputs are synchronous to sys_clk, so a plain edge detect is safe
        if (crystalRef && !crystalPrev)
        begin
            next_phaseCnt = (phaseCnt == PHASE_LAST) ? 2'h0 : phaseCnt + 2'h1; // [R7]
        end
        next_phaseTwo = (next_phaseCnt >= brcd_pkg::PHASE_TWO_START); // [R7]
        phaseTwoRise = next_phaseTwo && !procPhaseTwo;
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            crystalPrev <= 1'b0;
            phaseCnt <= 2'h0;
            procPhaseOne <= 1'b1;
            procPhaseTwo <= 1'b0;
            phaseTwoClk <= 1'b0;
        end
        else if (clkEn)
        begin
            crystalPrev <= crystalRef;
            phaseCnt <= next_phaseCnt;
            procPhaseOne <= !next_phaseTwo; // [R7]
            procPhaseTwo <= next_phaseTwo;
            phaseTwoClk <= next_phaseTwo; // [R7]
        end
    end

    // ----------------------------------------------------------------
    // peripheral reset holds and timer clock source
    // ----------------------------------------------------------------
    logic gatePrev;
    logic next_timerCountTick;

    always_comb
    begin
        // halted timers see no count edge at all while reset is low
        if (!next_boardResetN) // [R4]
        begin
            next_timerCountTick = 1'b0;
        end
        else if (timerSourceExt)
        begin
            next_timerCountTick = timerExtGate && !gatePrev; // [R12]
        end
        else
        begin
            next_timerCountTick = phaseTwoRise; // [R12]
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            gatePrev <= 1'b0;
            timerCountTick <= 1'b0;
            timerPresetHold <= 1'b1;
            portClearHold <= 1'b1;
        end
        else if (clkEn)
        begin
            gatePrev <= timerExtGate;
            timerCountTick <= next_timerCountTick;
            // preset to maximum count, flags cleared and internal reset bit set inside the timer chip
            timerPresetHold <= !next_boardResetN; // [R3] [R4]
            portClearHold <= !next_boardResetN; // [R5]
        end
    end

    // ----------------------------------------------------------------
    // chip selects
    // ----------------------------------------------------------------
    brcd_dec_if decBus ();
    logic next_periphSelect;
    logic next_romOneSelect;
    logic next_romTwoSelect;
    logic cycleOk;

    assign decBus.addrHigh = addrBus[15:10]; // [R8]

    brcd_addr_decoder #(.ROM_AT_TOP(ROM_AT_TOP)) u_decoder
    (
        .dec(decBus.decoder)
    );

    always_comb
    begin
        // scratch ram decodes to block zero, which holds no board device
        cycleOk = validMemoryCycle && next_boardResetN && (addrBus > brcd_pkg::SCRATCH_END); // [R11] [R13]
        next_periphSelect = cycleOk && decBus.periphHit; // [R9]
        next_romOneSelect = cycleOk && decBus.romOneHit; // [R9]
        next_romTwoSelect = cycleOk && decBus.romTwoHit; // [R9]
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            periphSelect <= 1'b0;
            romSocketOneSelect <= 1'b0;
            romSocketTwoSelect <= 1'b0;
        end
        else if (clkEn)
        begin
            periphSelect <= next_periphSelect;
            romSocketOneSelect <= next_romOneSelect;
            romSocketTwoSelect <= next_romTwoSelect;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [15:0] lowLen;

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lowLen <= 16'h0000;
        end
        else if (boardResetN)
        begin
            lowLen <= 16'h0000;
        end
        else if (lowLen != 16'hFFFF)
        begin
            lowLen <= lowLen + 16'h0001;
        end
    end

    a_reset_min_low: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R2]
        $rose(boardResetN) |-> lowLen >= MIN_LOAD)
        else $error("board reset released before a valid low time");

    a_ext_reset_hold: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R6]
        (!extResetN && clkEn) |=> !boardResetN ##1 !boardResetN)
        else $error("connector reset not applied to the board");

    a_timer_quiet: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R4]
        timerPresetHold |-> !timerCountTick && !boardResetN)
        else $error("timer counted while held in reset");

    a_port_clear: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R5]
        $fell(boardResetN) |-> portClearHold && timerPresetHold)
        else $error("port clear not applied with reset");

    a_phase_split: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R7]
        $rose(procPhaseTwo) |-> $past(procPhaseOne) && !procPhaseOne && phaseTwoClk)
        else $error("processor phases overlap");

    a_periph_window: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R10]
        (clkEn && validMemoryCycle && next_boardResetN && addrBus[15:10] == 6'h39) |=> periphSelect)
        else $error("peripheral block not selected");

    a_rom_window: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R10]
        (clkEn && validMemoryCycle && next_boardResetN && addrBus[15:11] == (ROM_AT_TOP ? 5'h1E : 5'h18))
        |=> romSocketOneSelect && !romSocketTwoSelect)
        else $error("rom socket one not selected");

    a_no_scratch: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R11]
        (clkEn && addrBus <= 16'h007F) |=> !(periphSelect || romSocketOneSelect || romSocketTwoSelect))
        else $error("board select raised for scratch ram");

    a_idle_quiet: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R13]
        (clkEn && !validMemoryCycle) |=> !(periphSelect || romSocketOneSelect || romSocketTwoSelect))
        else $error("select raised in an idle cycle");

    c_por_release: cover property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(boardResetN));
    c_ext_reset: cover property (@(posedge sys_clk) disable iff (!arst_n)
        boardResetN ##1 !boardResetN);
    c_rom_two: cover property (@(posedge sys_clk) disable iff (!arst_n)
        romSocketTwoSelect);
    c_ext_tick: cover property (@(posedge sys_clk) disable iff (!arst_n)
        timerSourceExt && timerCountTick);

endmodule

// >>> brcd_far_model.sv
// far side model: crystal source, processor bus master and bus connector reset
`timescale 1ns/1ps
module brcd_far_model
(
    input wire logic sys_clk,
    output logic crystalRef,
    output logic [15:0] addrBus,
    output logic validMemoryCycle,
    output logic extResetN
);
    int xtalCnt = 0;

    initial
    begin
        crystalRef = 1'b0;
        addrBus = 16'h0000;
        validMemoryCycle = 1'b0;
        extResetN = 1'b1;
    end

    // the oscillator runs free: five sys cycles a level is 4 MHz
    always @(negedge sys_clk)
    begin
        xtalCnt <= (xtalCnt == 4) ? 0 : xtalCnt + 1;
        if (xtalCnt == 4)
        begin
            crystalRef <= ~crystalRef;
        end
    end

    // hold address and valid for the given number of cycles
    task automatic busCycle(input logic [15:0] addr, input logic valid, input int cycles);
        @(negedge sys_clk);
        addrBus = addr;
        validMemoryCycle = valid;
        repeat (cycles) @(negedge sys_clk);
    endtask

    // an idle bus carries garbage, never the last address
    task automatic busIdle();
        @(negedge sys_clk);
        validMemoryCycle = 1'b0;
        addrBus = ~addrBus;
    endtask

    task automatic connectorReset(input int lowCycles);
        @(negedge sys_clk);
        extResetN = 1'b0;
        repeat (lowCycles) @(negedge sys_clk);
        extResetN = 1'b1;
    endtask
endmodule

// >>> brcd_top_test.sv
// self-checking bench for the board reset, clock and decode block
`timescale 1ns/1ps
module brcd_top_test;
    // smallest power-on count the block accepts keeps the run short
    localparam int POR = 321;
    localparam int STRETCH = brcd_pkg::MIN_LOW_CYCLES;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic clkEn = 1'b1;
    logic timerSourceExt = 1'b0;
    logic timerExtGate = 1'b0;
    logic crystalRef, validMemoryCycle, extResetN;
    logic [15:0] addrBus;
    logic boardResetN, procPhaseOne, procPhaseTwo, phaseTwoClk, periphSelect;
    logic romSocketOneSelect, romSocketTwoSelect, timerPresetHold, timerCountTick, portClearHold;
    logic topPeriph, topRomOne, topRomTwo;
    int n_fail = 0;
    int checks_done = 0;

    always #12.5 sys_clk = ~sys_clk;

    brcd_far_model far
    (
        .sys_clk(sys_clk), .crystalRef(crystalRef), .addrBus(addrBus),
        .validMemoryCycle(validMemoryCycle), .extResetN(extResetN)
    );

    brcd_top #(.POR_CYCLES(POR), .ROM_AT_TOP(1'b0)) dut
    (
        .sys_clk(sys_clk), .arst_n(arst_n), .clkEn(clkEn), .crystalRef(crystalRef),
        .extResetN(extResetN), .addrBus(addrBus), .validMemoryCycle(validMemoryCycle),
        .timerSourceExt(timerSourceExt), .timerExtGate(timerExtGate), .boardResetN(boardResetN),
        .procPhaseOne(procPhaseOne), .procPhaseTwo(procPhaseTwo), .phaseTwoClk(phaseTwoClk),
        .periphSelect(periphSelect), .romSocketOneSelect(romSocketOneSelect),
        .romSocketTwoSelect(romSocketTwoSelect), .timerPresetHold(timerPresetHold),
        .timerCountTick(timerCountTick), .portClearHold(portClearHold)
    );

    brcd_top #(.POR_CYCLES(POR), .ROM_AT_TOP(1'b1)) dutRomTop
    (
        .sys_clk(sys_clk), .arst_n(arst_n), .clkEn(clkEn), .crystalRef(crystalRef),
        .extResetN(extResetN), .addrBus(addrBus), .validMemoryCycle(validMemoryCycle),
        .timerSourceExt(timerSourceExt), .timerExtGate(timerExtGate), .boardResetN(),
        .procPhaseOne(), .procPhaseTwo(), .phaseTwoClk(), .periphSelect(topPeriph),
        .romSocketOneSelect(topRomOne), .romSocketTwoSelect(topRomTwo), .timerPresetHold(),
        .timerCountTick(), .portClearHold()
    );

    task automatic summarize();
        if (n_fail == 0 && checks_done > 0)
        begin
            $display("bench passed");
        end
        else
        begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic checkBit(input string what, input logic exp, input logic seen);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %b seen %b", what, exp, seen);
        end
    endtask

    task automatic checkSel(input string what, input logic [2:0] exp, input logic [2:0] seen);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %b seen %b", what, exp, seen);
        end
    endtask

    task automatic checkRange(input string what, input int lo, input int hi, input int seen);
        checks_done++;
        if (seen < lo || seen > hi)
        begin
            n_fail++;
            $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, seen);
        end
    endtask

    task automatic giveUp(input string what);
        n_fail++;
        $display("mismatch %s expected done seen timeout", what);
        summarize();
    endtask

    task automatic lowCycles(inout int n);
        while (boardResetN !== 1'b1)
        begin
            @(negedge sys_clk);
            n++;
            if (n > 2000) giveUp("reset release");
        end
    endtask

    task automatic waitTwo(input logic level, output int n);
        n = 0;
        while (phaseTwoClk !== level)
        begin
            @(negedge sys_clk);
            n++;
            if (n > 100) giveUp("phase two");
        end
    endtask

    task automatic countTicks(input int cycles, output int t);
        t = 0;
        repeat (cycles)
        begin
            @(negedge sys_clk);
            if (timerCountTick === 1'b1) t++;
        end
    endtask

    // selects as {periph, socket one, socket two}
    function automatic logic [2:0] expSel(input logic [15:0] a, input logic v, input logic top);
        logic [15:0] base;
        base = top ? 16'hF000 : 16'hC000;
        expSel = 3'h0;
        if (v && a >= 16'hE400 && a <= 16'hE7FF) expSel = 3'h4;
        if (v && a >= base && a <= base + 16'h07FF) expSel = 3'h2;
        if (v && a >= base + 16'h0800 && a <= base + 16'h0FFF) expSel = 3'h1;
    endfunction

    task automatic checkPowerOn();
        int n;
        n = 0;
        far.busCycle(16'hE400, 1'b1, 0);
        arst_n = 1'b1;
        checkBit("reset held", 1'b0, boardResetN);
        checkBit("timer preset", 1'b1, timerPresetHold);
        checkBit("port clear", 1'b1, portClearHold);
        lowCycles(n);
        checkRange("power-on low", POR + STRETCH - 1, POR + STRETCH + 2, n);
        checkBit("timer preset end", 1'b0, timerPresetHold);
        checkBit("port clear end", 1'b0, portClearHold);
        far.busIdle();
    endtask

    task automatic checkClock();
        int hi;
        int lo;
        int moves;
        logic held;
        waitTwo(1'b0, hi);
        waitTwo(1'b1, lo);
        waitTwo(1'b0, hi);
        waitTwo(1'b1, lo);
        checkRange("phase two high", 20, 20, hi);
        checkRange("phase two low", 20, 20, lo);
        checkBit("phase two", 1'b1, procPhaseTwo);
        checkBit("phase one", 1'b0, procPhaseOne);
        clkEn = 1'b0;
        held = phaseTwoClk;
        moves = 0;
        repeat (60)
        begin
            @(negedge sys_clk);
            if (phaseTwoClk !== held) moves++;
        end
        checkRange("frozen phase", 0, 0, moves);
        clkEn = 1'b1;
    endtask

    task automatic checkDecode();
        logic [15:0] addrs [16] = '{16'hE400, 16'hE7FF, 16'hE413, 16'hE3FF, 16'hE800, 16'hC000,
            16'hC7FF, 16'hC800, 16'hCFFF, 16'hD000, 16'hF000, 16'hF7FF, 16'hF800, 16'hFFFF,
            16'h007F, 16'h0000};
        for (int i = 0; i < 16; i++)
        begin
            for (int v = 0; v < 2; v++)
            begin
                far.busCycle(addrs[i], v[0], 2);
                checkSel("low rom map", expSel(addrs[i], v[0], 1'b0),
                    {periphSelect, romSocketOneSelect, romSocketTwoSelect});
                checkSel("top rom map", expSel(addrs[i], v[0], 1'b1),
                    {topPeriph, topRomOne, topRomTwo});
                far.busIdle();
            end
        end
    endtask

    task automatic checkTicks();
        int t;
        countTicks(400, t);
        checkRange("internal ticks", 10, 10, t);
        timerSourceExt = 1'b1;
        repeat (2) @(negedge sys_clk);
        fork
            countTicks(60, t);
            repeat (3)
            begin
                @(negedge sys_clk);
                timerExtGate = 1'b1;
                repeat (5) @(negedge sys_clk);
                timerExtGate = 1'b0;
                repeat (5) @(negedge sys_clk);
            end
        join
        checkRange("external ticks", 3, 3, t);
        timerSourceExt = 1'b0;
    endtask

    task automatic checkConnectorReset();
        int n;
        int t;
        n = 0;
        fork
            far.connectorReset(330);
            begin
                repeat (4) @(negedge sys_clk);
                checkBit("connector reset", 1'b0, boardResetN);
                checkBit("connector preset", 1'b1, timerPresetHold);
                checkBit("connector clear", 1'b1, portClearHold);
                countTicks(100, t);
                checkRange("ticks in reset", 0, 0, t);
            end
        join
        lowCycles(n);
        checkRange("stretch low", STRETCH - 1, STRETCH + 2, n);
    endtask

    initial
    begin
        repeat (1) @(negedge sys_clk);
        checkPowerOn();
        checkClock();
        checkDecode();
        checkTicks();
        checkConnectorReset();
        summarize();
    end
endmodule
